// File: hw/uaid_params.svh
// Register map, field layout, reset values and timing counts of the accessory identifier
`ifndef UAID_PARAMS_SVH
`define UAID_PARAMS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UAID_OFF_CTRL 12'h000
`define UAID_OFF_IRQ 12'h004
`define UAID_OFF_SENSE 12'h008
`define UAID_OFF_DEVTYPE 12'h00C
`define UAID_OFF_ADC 12'h010
// ---------------------------------------------------------------
// Control register layout and reset value
// ---------------------------------------------------------------
`define UAID_CTRL_RST 32'h0000006C
`define UAID_CTRL_VDB_LSB 0
`define UAID_CTRL_VTH_LSB 2
`define UAID_CTRL_VTL_LSB 5
`define UAID_CTRL_ODB_LSB 8
`define UAID_CTRL_MASK 32'h000003FF
// ---------------------------------------------------------------
// Event flag bits (write one to clear)
// ---------------------------------------------------------------
`define UAID_IRQ_ATTACH 0
`define UAID_IRQ_UNKNOWN 1
`define UAID_IRQ_VBUSDET 2
`define UAID_IRQ_OVP 3
`define UAID_IRQ_DETACH 4
`define UAID_IRQ_W 5
// ---------------------------------------------------------------
// Device type bits
// ---------------------------------------------------------------
`define UAID_DT_USB 0
`define UAID_DT_UART 1
`define UAID_DT_AUDIO1 2
`define UAID_DT_TTY 3
`define UAID_DT_USBJIG 4
`define UAID_DT_UARTJIG 5
`define UAID_DT_W 6
// ---------------------------------------------------------------
// ID converter codes
// ---------------------------------------------------------------
`define UAID_ADC_SHORT 5'h00
`define UAID_ADC_FLOAT 5'h1F
`define UAID_ADC_UART 5'h18
`define UAID_ADC_AUDIO1 5'h0E
`define UAID_ADC_TTY 5'h10
`define UAID_ADC_USBJIG 5'h19
`define UAID_ADC_UARTJIG 5'h1C
// ---------------------------------------------------------------
// Timing on the 32 kHz tick
// ---------------------------------------------------------------
`define UAID_RTC_HZ 32768
`define UAID_VBUS_DB_STEP_MS 10
`define UAID_VBUS_DB_STEP_TICKS ((`UAID_VBUS_DB_STEP_MS * `UAID_RTC_HZ + 999) / 1000)
`define UAID_KEY_POLL_MS 20
`define UAID_KEY_POLL_TICKS ((`UAID_KEY_POLL_MS * `UAID_RTC_HZ) / 1000)
`endif

// File: hw/uaid_pkg.sv
// Types shared by the accessory identifier modules
package uaid_pkg;
  // Identification flow states, one-hot
  typedef enum logic [4:0] {
    UAID_IDLE = 5'b00001,
    UAID_ACTIVE = 5'b00010,
    UAID_DECIDE = 5'b00100,
    UAID_ATTACHED = 5'b01000,
    UAID_DETACH = 5'b10000
  } uaid_state_t;

  // Analog comparator outputs from the connector front end
  typedef struct packed {
    logic id_low;
    logic vbus_above_high;
    logic vbus_below_low;
    logic vbus_overvoltage;
  } uaid_comp_t;

  // Software control fields
  typedef struct packed {
    logic [1:0] overvoltage_debounce_sel;
    logic [2:0] vbus_low_threshold_sel;
    logic [2:0] vbus_high_threshold_sel;
    logic [1:0] vbus_debounce_sel;
  } uaid_ctrl_t;
endpackage

// File: hw/uaid_sync.sv
// Two-flop synchroniser, one chain per bit
module uaid_sync #(
  parameter int W = 5
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  // ---------------------------------------------------------------
  // Synchroniser chains
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic meta_q; // First stage, read only by second
      logic sync_q; // Second stage
      // Shift the pin through two flops
      always_ff @(posedge i_mclk) begin
        if (i_reset) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate
endmodule

// File: hw/uaid_debounce.sv
// Rising-edge debounce counted in 32 kHz ticks, immediate fall
module uaid_debounce #(
  parameter int CW = 10
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_level,
  input wire logic [CW-1:0] i_target,
  output logic o_stable
);
  logic [CW-1:0] cnt_q; // Ticks spent high

  // ---------------------------------------------------------------
  // Count ticks while the level stays high
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset || !i_level) begin
      cnt_q <= '0;
    end else if (i_tick && (cnt_q < i_target)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Qualified output, dropped at once with the level
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_stable <= 1'b0;
    end else begin
      o_stable <= i_level && (cnt_q >= i_target);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_db_drop: assert property (@(posedge i_mclk) disable iff (i_reset)
    !i_level |=> !o_stable) else $error("debounce output held after level fell");
  a_db_wait: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(o_stable) |-> $past(cnt_q) >= $past(i_target))
    else $error("debounce output rose before target");
endmodule

// File: hw/uaid_core.sv
// Accessory identification: ID and VBUS monitoring, ID conversion, flags and APB registers
//
// Our own choices: the APB interface to the registers and the address map.
`include "uaid_params.svh"

// Contract
// - Watch ID and VBUS; attach enters Active (a VBUS attach with ID floating goes from Idle straight to Decide)
// - Known accessory sets type bit, attach
// - Unidentified accessory sets unknown-attach flag
// - Identify USB, UART, audio, TTY, jigs
// - Debounced VBUS rise raises detect, sense
// - VBUS below low: immediate event, sense low
// - Debounce codes give 0/10/20/30 ms
// - Threshold selects, eight steps, default 011
// - Over-voltage during attach raises event
// - Over-voltage debounce 0/2/4/8 RTC cycles
// - ID floating sense from comparator
// - Falling ID sense starts identification
// - Rising ID sense starts detachment
// - Done signal marks identification end
// - Identification launches one ID conversion
// - Conversion end sets status, stores result
// - Conversion enable clears itself
// - Short gives 00000, floating gives 11111
// - Audio cable: converter reads remote keys
module uaid_core (
  input wire logic i_mclk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // 32 kHz real-time clock and analog front end
  input wire logic i_rtc_clk,
  input wire uaid_pkg::uaid_comp_t i_comp,
  output logic [2:0] o_vbus_high_threshold_sel,
  output logic [2:0] o_vbus_low_threshold_sel,
  // ID converter
  output logic o_adc_en,
  input wire logic i_adc_done,
  input wire logic [4:0] i_adc_data,
  // Status to the chip
  output logic o_id_detection_done,
  output logic [`UAID_DT_W-1:0] o_device_type
);
  import uaid_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  uaid_state_t state_q; // Identification flow state
  uaid_state_t state_d; // Next state
  uaid_ctrl_t ctrl_q; // Software control fields
  uaid_comp_t comp_s; // Synchronised comparators
  logic rtc_s; // Synchronised RTC clock
  logic rtc_prev_q; // RTC level one cycle ago
  logic tick; // One-cycle 32 kHz tick
  logic id_float_q; // ID floating sense
  logic id_float_d; // Next ID floating sense
  logic id_fall; // ID resistor connected
  logic id_rise; // ID resistor removed
  logic above_high_q; // Sampled high comparator
  logic below_low_q; // Sampled low comparator
  logic ovp_q; // Sampled over-voltage comparator
  logic vbus_ok; // Debounced VBUS rise
  logic ovp_ok; // Debounced over-voltage
  logic ovp_prev_q; // Over-voltage one cycle ago
  logic vbus_sense_q; // VBUS detect sense
  logic vbus_sense_d; // Next VBUS detect sense
  logic [9:0] vbus_target; // VBUS debounce ticks
  logic [9:0] ovp_target; // Over-voltage debounce ticks
  logic adc_en_q; // Conversion enable
  logic conv_done; // Conversion finished this cycle
  logic conv_start; // Launch a conversion
  logic adc_status_q; // Conversion status
  logic [4:0] adc_result_q; // Latest ID code
  logic [4:0] key_q; // Latest remote key code
  logic key_valid_q; // A key is pressed
  logic [9:0] poll_q; // Key poll counter
  logic poll_fire; // Key poll due
  logic id_done_q; // Identification finished
  logic [`UAID_DT_W-1:0] dev_type_q; // Identified device
  logic [`UAID_DT_W-1:0] dev_class; // Device from code
  logic [`UAID_IRQ_W-1:0] irq_q; // Sticky event flags
  logic [`UAID_IRQ_W-1:0] irq_set; // Events this cycle
  logic [`UAID_IRQ_W-1:0] irq_clr; // Software clears
  logic wr_en; // APB write taken
  logic setup; // APB setup phase
  logic addr_hit; // Mapped address
  logic [31:0] rdata; // Read mux

  // ---------------------------------------------------------------
  // Synchronisers and 32 kHz tick
  // ---------------------------------------------------------------
  uaid_sync #(
    .W(5)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_rtc_clk, i_comp}),
    .o_sync({rtc_s, comp_s})
  );

  // Remember RTC level for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rtc_prev_q <= 1'b0;
    end else begin
      rtc_prev_q <= rtc_s;
    end
  end
  assign tick = rtc_s && !rtc_prev_q;

  // Sample comparators on the tick only
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      above_high_q <= 1'b0;
      below_low_q <= 1'b1;
      ovp_q <= 1'b0;
    end else if (tick) begin
      above_high_q <= comp_s.vbus_above_high;
      below_low_q <= comp_s.vbus_below_low;
      ovp_q <= comp_s.vbus_overvoltage;
    end
  end

  // ---------------------------------------------------------------
  // ID floating sense and its edges
  // ---------------------------------------------------------------
  assign id_float_d = tick ? !comp_s.id_low : id_float_q;
  assign id_fall = id_float_q && !id_float_d;
  assign id_rise = !id_float_q && id_float_d;

  // Floating after reset, no accessory yet
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      id_float_q <= 1'b1;
    end else begin
      id_float_q <= id_float_d;
    end
  end

  // ---------------------------------------------------------------
  // VBUS detection and over-voltage
  // ---------------------------------------------------------------
  assign vbus_target = 10'(ctrl_q.vbus_debounce_sel * `UAID_VBUS_DB_STEP_TICKS);
  assign ovp_target = (ctrl_q.overvoltage_debounce_sel == 2'h0) ? 10'h000 :
                      (10'h001 << ctrl_q.overvoltage_debounce_sel);

  uaid_debounce #(
    .CW(10)
  ) u_vbus_db (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_level(above_high_q),
    .i_target(vbus_target),
    .o_stable(vbus_ok)
  );

  uaid_debounce #(
    .CW(10)
  ) u_ovp_db (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_level(ovp_q),
    .i_target(ovp_target),
    .o_stable(ovp_ok)
  );

  // Low threshold clears at once, debounced high sets
  always_comb begin
    if (below_low_q) begin
      vbus_sense_d = 1'b0;
    end else if (vbus_ok) begin
      vbus_sense_d = 1'b1;
    end else begin
      vbus_sense_d = vbus_sense_q;
    end
  end

  // Sense and over-voltage history
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      vbus_sense_q <= 1'b0;
      ovp_prev_q <= 1'b0;
    end else begin
      vbus_sense_q <= vbus_sense_d;
      ovp_prev_q <= ovp_ok;
    end
  end

  // ---------------------------------------------------------------
  // Identification flow
  // ---------------------------------------------------------------
  assign conv_done = adc_en_q && i_adc_done;
  assign poll_fire = (state_q == UAID_ATTACHED) && dev_type_q[`UAID_DT_AUDIO1] &&
                     tick && (poll_q == 10'(`UAID_KEY_POLL_TICKS)) && !adc_en_q;
  assign conv_start = ((state_q == UAID_IDLE) && id_fall) || poll_fire;

  // Map the stored code to a device type
  always_comb begin
    dev_class = '0;
    case (adc_result_q)
      `UAID_ADC_UART: dev_class[`UAID_DT_UART] = 1'b1;
      `UAID_ADC_AUDIO1: dev_class[`UAID_DT_AUDIO1] = 1'b1;
      `UAID_ADC_TTY: dev_class[`UAID_DT_TTY] = 1'b1;
      `UAID_ADC_USBJIG: dev_class[`UAID_DT_USBJIG] = 1'b1;
      `UAID_ADC_UARTJIG: dev_class[`UAID_DT_UARTJIG] = 1'b1;
      `UAID_ADC_FLOAT: dev_class[`UAID_DT_USB] = vbus_sense_q;
      default: dev_class = '0;
    endcase
  end

  // Next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      UAID_IDLE: begin
        if (id_fall) begin
          state_d = UAID_ACTIVE;
        end else if (id_float_q && vbus_sense_d && !vbus_sense_q) begin
          state_d = UAID_DECIDE;
        end
      end
      UAID_ACTIVE: begin
        if (id_rise) begin
          state_d = UAID_DETACH;
        end else if (conv_done) begin
          state_d = UAID_DECIDE;
        end
      end
      UAID_DECIDE: state_d = UAID_ATTACHED;
      UAID_ATTACHED: begin
        if (id_rise || (dev_type_q[`UAID_DT_USB] && !vbus_sense_q)) begin
          state_d = UAID_DETACH;
        end
      end
      UAID_DETACH: state_d = UAID_IDLE;
      default: state_d = UAID_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= UAID_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Conversion enable, dropped by hardware on completion
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      adc_en_q <= 1'b0;
    end else if (conv_start) begin
      adc_en_q <= 1'b1;
    end else if (conv_done || (state_q == UAID_DETACH)) begin
      adc_en_q <= 1'b0;
    end
  end

  // Store conversion result, floating ID forced to all ones
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      adc_result_q <= `UAID_ADC_FLOAT;
      adc_status_q <= 1'b0;
    end else if (conv_done && (state_q == UAID_ACTIVE)) begin
      adc_result_q <= id_float_q ? `UAID_ADC_FLOAT : i_adc_data;
      adc_status_q <= 1'b1;
    end else if (state_q == UAID_DETACH) begin
      adc_status_q <= 1'b0;
    end
  end

  // Remote key reads while the audio cable stays attached
  always_ff @(posedge i_mclk) begin
    if (i_reset || (state_q != UAID_ATTACHED)) begin
      key_q <= '0;
      key_valid_q <= 1'b0;
      poll_q <= '0;
    end else begin
      if (tick) begin
        poll_q <= poll_fire ? 10'h000 : poll_q + 10'h001;
      end
      if (conv_done) begin
        key_q <= i_adc_data;
        key_valid_q <= (i_adc_data < `UAID_ADC_AUDIO1);
      end
    end
  end

  // Device type and identification-done marker
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dev_type_q <= '0;
      id_done_q <= 1'b0;
    end else if (state_q == UAID_DECIDE) begin
      dev_type_q <= id_float_q ? {{(`UAID_DT_W-1){1'b0}}, vbus_sense_q} : dev_class;
      id_done_q <= 1'b1;
    end else if (state_q == UAID_DETACH) begin
      dev_type_q <= '0;
      id_done_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sticky event flags
  // ---------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    if (state_q == UAID_DECIDE) begin
      if (id_float_q ? vbus_sense_q : (dev_class != '0)) begin
        irq_set[`UAID_IRQ_ATTACH] = 1'b1;
      end else begin
        irq_set[`UAID_IRQ_UNKNOWN] = 1'b1;
      end
    end
    irq_set[`UAID_IRQ_VBUSDET] = vbus_sense_d != vbus_sense_q;
    irq_set[`UAID_IRQ_OVP] = ovp_ok && !ovp_prev_q && (state_q != UAID_IDLE);
    irq_set[`UAID_IRQ_DETACH] = state_q == UAID_DETACH;
  end
  assign irq_clr = (wr_en && (i_paddr == `UAID_OFF_IRQ)) ? i_pwdata[`UAID_IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_q <= '0;
    end else begin
      irq_q <= (irq_q & ~irq_clr) | irq_set;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign addr_hit = (i_paddr == `UAID_OFF_CTRL) || (i_paddr == `UAID_OFF_IRQ) ||
                    (i_paddr == `UAID_OFF_SENSE) || (i_paddr == `UAID_OFF_DEVTYPE) ||
                    (i_paddr == `UAID_OFF_ADC);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;

  // Read mux, unmapped reads as zero
  always_comb begin
    case (i_paddr)
      `UAID_OFF_CTRL: rdata = {22'h000000, ctrl_q};
      `UAID_OFF_IRQ: rdata = {27'h0000000, irq_q};
      `UAID_OFF_SENSE: rdata = {27'h0000000, adc_status_q, id_done_q, ovp_ok,
                                vbus_sense_q, id_float_q};
      `UAID_OFF_DEVTYPE: rdata = {26'h0000000, dev_type_q};
      `UAID_OFF_ADC: rdata = {15'h0000, key_valid_q, 3'h0, key_q, 3'h0, adc_result_q};
      default: rdata = 32'h00000000;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_prdata <= 32'h00000000;
    end else if (setup) begin
      o_prdata <= rdata;
    end
  end

  // Control register, thresholds default to code 011
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q <= uaid_ctrl_t'(10'(`UAID_CTRL_RST));
    end else if (wr_en && (i_paddr == `UAID_OFF_CTRL)) begin
      ctrl_q <= uaid_ctrl_t'(i_pwdata[9:0]);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_vbus_high_threshold_sel = ctrl_q.vbus_high_threshold_sel;
  assign o_vbus_low_threshold_sel = ctrl_q.vbus_low_threshold_sel;
  assign o_adc_en = adc_en_q;
  assign o_id_detection_done = id_done_q;
  assign o_device_type = dev_type_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_id_attach;
    (state_q == UAID_IDLE) && id_fall;
  endsequence
  sequence s_conv_end;
    adc_en_q && i_adc_done && (state_q == UAID_ACTIVE) && !id_rise;
  endsequence

  a_id_start: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_id_attach |=> (state_q == UAID_ACTIVE) && adc_en_q)
    else $error("ID fall did not start identification");
  a_adc_self_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
    (adc_en_q && i_adc_done && !conv_start) |=> !adc_en_q)
    else $error("conversion enable not cleared");
  a_conv_result: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_conv_end ##1 1'b1 |-> adc_status_q && (state_q == UAID_DECIDE))
    else $error("conversion end not recorded");
  a_short_code: assert property (@(posedge i_mclk) disable iff (i_reset)
    (s_conv_end and (i_adc_data == 5'h00)) |=> (adc_result_q == 5'h00))
    else $error("shorted ID not coded all zeros");
  a_attach_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == UAID_DECIDE) && !id_float_q && (dev_class != '0)
      |=> irq_q[`UAID_IRQ_ATTACH] && (dev_type_q == $past(dev_class)))
    else $error("attach not flagged");
  a_unknown_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == UAID_DECIDE) && !id_float_q && (dev_class == '0)
      |=> irq_q[`UAID_IRQ_UNKNOWN] && (dev_type_q == '0))
    else $error("unknown accessory not flagged");
  a_vbus_event: assert property (@(posedge i_mclk) disable iff (i_reset)
    $changed(vbus_sense_q) |-> irq_q[`UAID_IRQ_VBUSDET])
    else $error("VBUS change without event");
  a_vbus_drop: assert property (@(posedge i_mclk) disable iff (i_reset)
    below_low_q |=> !vbus_sense_q) else $error("VBUS sense held below low threshold");
  a_detach_seq: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == UAID_ATTACHED) && id_rise |=> (state_q == UAID_DETACH) ##1 !id_done_q)
    else $error("detachment not started");
  a_done_mark: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == UAID_DECIDE) |=> id_done_q [*1] ##0 (state_q == UAID_ATTACHED))
    else $error("identification end not marked");
  a_tick_sample: assert property (@(posedge i_mclk) disable iff (i_reset)
    !tick |=> $stable(id_float_q) && $stable(above_high_q))
    else $error("comparator sampled off tick");
endmodule

// File: tb/uaid_adc_model.sv
// Behavioural ID converter that answers each conversion request after a chosen lag
module uaid_adc_model (
  input wire logic i_mclk,
  input wire logic i_adc_en,
  input wire logic [4:0] i_code,
  input wire logic [3:0] i_lag,
  output logic o_done,
  output logic [4:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Waits for a request, then gives a one-cycle done pulse with the code
  initial begin
    o_done = 1'b0;
    o_data = 5'h00;
    forever begin
      @(posedge i_mclk);
      if (i_adc_en === 1'b1) begin
        repeat (i_lag) @(posedge i_mclk);
        o_done <= 1'b1;
        o_data <= i_code;
        @(posedge i_mclk);
        o_done <= 1'b0;
        // Inverted code so a stale value is never taken for valid
        o_data <= ~i_code;
      end
    end
  end
endmodule

// File: tb/usb_accessory_identification_tb.sv
// Self-checking bench for the accessory identifier
module usb_accessory_identification_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uaid_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_rtc_clk = 1'b0;
  uaid_comp_t i_comp = '0;
  logic [4:0] code = 5'h00;
  logic [3:0] lag = 4'h1;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, err, o_adc_en, i_adc_done, o_id_detection_done;
  logic [2:0] o_vbus_high_threshold_sel, o_vbus_low_threshold_sel;
  logic [4:0] i_adc_data;
  logic [5:0] o_device_type;
  int errors = 0;
  int total_checks = 0;
  uaid_core dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rtc_clk(i_rtc_clk), .i_comp(i_comp),
    .o_vbus_high_threshold_sel(o_vbus_high_threshold_sel),
    .o_vbus_low_threshold_sel(o_vbus_low_threshold_sel), .o_adc_en(o_adc_en),
    .i_adc_done(i_adc_done), .i_adc_data(i_adc_data),
    .o_id_detection_done(o_id_detection_done), .o_device_type(o_device_type));
  uaid_adc_model adc (.i_mclk(i_mclk), .i_adc_en(o_adc_en), .i_code(code), .i_lag(lag),
    .o_done(i_adc_done), .o_data(i_adc_data));
  // Clocks: 125 MHz main, fast stand-in for the 32 kHz tick source
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    forever begin
      repeat (20) @(posedge i_mclk);
      i_rtc_clk <= ~i_rtc_clk;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Bounded wait on done (k=0) or the USB type bit (k=1)
  task automatic wt(input int k, input logic want);
    for (int n = 0; n < 3000; n++) begin
      @(negedge i_mclk);
      if ((k == 0 ? o_id_detection_done : o_device_type[0]) === want) return;
    end
    // Limit ran out: count it as a mismatch
    errors++;
  endtask
  task automatic t_regs;
    chk(o_device_type, 0);
    apb(0, 12'h000, 0);
    chk(rd, 32'h6C);
    chk({o_vbus_high_threshold_sel, o_vbus_low_threshold_sel}, 6'o33);
    apb(1, 12'h000, 32'h54);
    @(negedge i_mclk);
    chk({o_vbus_high_threshold_sel, o_vbus_low_threshold_sel}, 6'o52);
    apb(1, 12'h000, 32'h6C);
    apb(0, 12'h0FC, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(1, 12'h004, 32'h1F);
    $display("test registers done");
  endtask
  task automatic t_ident(input logic [4:0] c, input logic [5:0] ty, input logic [4:0] fl);
    code <= c;
    lag <= lag ^ 4'h8;
    i_comp.id_low <= 1'b1;
    wt(0, 1'b1);
    chk(o_device_type, ty);
    apb(0, 12'h004, 0);
    chk(rd, fl);
    apb(0, 12'h010, 0);
    chk(rd[4:0], c);
    apb(0, 12'h008, 0);
    chk({rd[4:3], rd[0]}, 3'b110);
    chk(o_adc_en, 0);
    i_comp.id_low <= 1'b0;
    wt(0, 1'b0);
    chk(o_device_type, 0);
    apb(0, 12'h004, 0);
    chk(rd[4], 1);
    apb(1, 12'h004, 32'h1F);
    $display("test identify %h done", c);
  endtask
  // Over-voltage while attached, debounce code 01 (two ticks)
  task automatic t_ovp;
    apb(1, 12'h000, 32'h16C);
    code <= 5'h18;
    i_comp.id_low <= 1'b1;
    wt(0, 1'b1);
    apb(1, 12'h004, 32'h1F);
    @(posedge i_rtc_clk);
    @(posedge i_mclk);
    i_comp.vbus_overvoltage <= 1'b1;
    repeat (86) @(posedge i_mclk);
    apb(0, 12'h004, 0);
    chk(rd[3], 0);
    repeat (60) @(posedge i_mclk);
    apb(0, 12'h004, 0);
    chk(rd[3], 1);
    apb(0, 12'h008, 0);
    chk(rd[2], 1);
    i_comp.vbus_overvoltage <= 1'b0;
    i_comp.id_low <= 1'b0;
    wt(0, 1'b0);
    apb(1, 12'h000, 32'h6C);
    apb(1, 12'h004, 32'h1F);
    $display("test overvoltage done");
  endtask
  task automatic t_vbus;
    i_comp.vbus_above_high <= 1'b1;
    wt(1, 1'b1);
    apb(0, 12'h008, 0);
    chk(rd[1], 1);
    apb(0, 12'h004, 0);
    chk(rd, 32'h5);
    apb(1, 12'h004, 32'h1F);
    i_comp.vbus_above_high <= 1'b0;
    i_comp.vbus_below_low <= 1'b1;
    wt(1, 1'b0);
    apb(0, 12'h008, 0);
    chk(rd[1], 0);
    apb(0, 12'h004, 0);
    chk(rd[2], 1);
    $display("test vbus done");
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge i_mclk);
    errors++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (200) @(posedge i_mclk);
    t_regs;
    t_ident(5'h18, 6'h02, 5'h1);
    t_ident(5'h0E, 6'h04, 5'h1);
    t_ident(5'h10, 6'h08, 5'h1);
    t_ident(5'h19, 6'h10, 5'h1);
    t_ident(5'h1C, 6'h20, 5'h1);
    t_ident(5'h00, 6'h00, 5'h2);
    t_ovp;
    t_vbus;
    summarize;
  end
endmodule
